// ==== vrc_top.sv ====
`timescale 1ns/10ps
//
// How it works
// - Power bit 7 set powers the ladder; clear powers it down.
// - Bit 6 set connects the reference to the output pin while bit 7 is set and port_f_direction is high.
// - Low range: level is tap times span over 24.
// - High range: level is quarter span plus tap times span over 32.
// - Bit 4 picks external reference pins or analog supply as span.
// - Low four bits are unsigned tap value 0 to 15.
// - Reset clears power, pin enable and tap bits.
// - Reset clears range select, choosing the high range.
// - Wake from sleep leaves the control register unchanged.
// - Reference works independently of comparator mode settings.
module vrc_top
	import vrc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	input  wire logic        port_f_direction,
	output      logic        ladder_power_on,
	output      logic        ref_output_pin_connect,
	output      logic        span_external,
	output      logic        low_range,
	output      logic [4:0]  tap_numerator,
	output      logic [3:0]  ref_tap_value
);

	////////////////////////////////////////////////////////////////////////
	vrc_ctrl_s   ctrl_r;
	vrc_ladder_s ladder_nxt;
	logic        setup;
	logic        hit;

	// Zero-wait slave: pready raised in the access cycle
	assign setup = psel & ~penable;
	assign hit   = (paddr == VRC_ADDR_CTRL);

	// No sleep input exists: sleep and wake never touch ctrl_r
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r <= vrc_ctrl_s'(VRC_CTRL_RESET);
		end else if (psel && penable && pready && pwrite && hit
			&& pstrb[0]) begin
			ctrl_r <= vrc_ctrl_s'(pwdata[7:0]);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit;
			if (setup && !pwrite && hit) begin
				prdata <= {24'h00_0000, ctrl_r};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	vrc_tap_decode u_dec (
		.ctrl   (ctrl_r),
		.ladder (ladder_nxt)
	);

	// Comparator mode is not an input, so it cannot gate the ladder
	always_ff @(posedge mclk) begin
		if (rst) begin
			ladder_power_on        <= 1'b0;
			ref_output_pin_connect <= 1'b0;
			span_external          <= 1'b0;
			low_range              <= 1'b0;
			tap_numerator          <= VRC_HIGH_OFFSET;
			ref_tap_value          <= 4'h0;
		end else begin
			ladder_power_on        <= ladder_nxt.ladder_on;
			// Pin only reached when software left direction as input
			ref_output_pin_connect <= ladder_nxt.pin_connect
				& port_f_direction;
			span_external          <= ladder_nxt.span_external;
			low_range              <= ladder_nxt.low_range;
			tap_numerator          <= ladder_nxt.tap_numerator;
			ref_tap_value          <= ctrl_r.ref_tap_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_RESET_CLEARS: assert property (@(posedge mclk)
		rst |=> ctrl_r == vrc_ctrl_s'(VRC_CTRL_RESET))
		else $error("Control not cleared by reset");

	AST_RESET_HIGH_RANGE: assert property (@(posedge mclk)
		rst ##1 rst |=> !low_range && tap_numerator == VRC_HIGH_OFFSET)
		else $error("Reset did not select high range");

	AST_POWER_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
		ladder_power_on == $past(ctrl_r.ref_power_enable))
		else $error("Ladder power does not follow enable bit");

	AST_PIN_CONNECT: assert property (@(posedge mclk) disable iff (rst)
		##1 ref_output_pin_connect == $past(ctrl_r.ref_pin_output_enable
		& ctrl_r.ref_power_enable & port_f_direction))
		else $error("Pin connection wrong");

	AST_LOW_TAP: assert property (@(posedge mclk) disable iff (rst)
		##1 $past(ctrl_r.ref_range_select) |->
		tap_numerator == {1'b0, $past(ctrl_r.ref_tap_value)})
		else $error("Low range tap wrong");

	AST_HIGH_TAP: assert property (@(posedge mclk) disable iff (rst)
		##1 !$past(ctrl_r.ref_range_select) |->
		tap_numerator == 5'h08 + {1'b0, $past(ctrl_r.ref_tap_value)})
		else $error("High range tap wrong");

	AST_SOURCE: assert property (@(posedge mclk) disable iff (rst)
		##1 span_external == $past(ctrl_r.ref_source_select))
		else $error("Source select wrong");

	AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (rst)
		psel && penable && pready && pwrite && hit && pstrb[0]
		|=> ctrl_r == $past(pwdata[7:0]) ##1
		ref_tap_value == $past(pwdata[3:0], 2))
		else $error("Write not applied");

	AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
		!(psel && penable && pwrite) |=> $stable(ctrl_r))
		else $error("Control changed without write");

	AST_READBACK: assert property (@(posedge mclk) disable iff (rst)
		setup && !pwrite && hit |=> pready && prdata[7:0] == $past(ctrl_r)
		&& prdata[31:8] == 24'h00_0000)
		else $error("Readback wrong");

endmodule

// ==== vrc_pkg.sv ====
package vrc_pkg;

	localparam logic [11:0] VRC_ADDR_CTRL    = 12'h000;
	localparam logic [7:0]  VRC_CTRL_RESET   = 8'h00;
	localparam int          VRC_BIT_POWER    = 7;
	localparam int          VRC_BIT_PIN_OE   = 6;
	localparam int          VRC_BIT_RANGE    = 5;
	localparam int          VRC_BIT_SOURCE   = 4;
	localparam int          VRC_TAP_MSB      = 3;
	localparam int          VRC_TAP_LSB      = 0;
	localparam logic [4:0]  VRC_LOW_DIVISOR  = 5'h18;
	localparam logic [4:0]  VRC_HIGH_DIVISOR = 5'h00;
	localparam logic [4:0]  VRC_HIGH_OFFSET  = 5'h08;

	typedef struct packed {
		logic       ref_power_enable;
		logic       ref_pin_output_enable;
		logic       ref_range_select;
		logic       ref_source_select;
		logic [3:0] ref_tap_value;
	} vrc_ctrl_s;

	// Ladder steering: binary tap numerator over 32 high-range or 24 low-range
	// segments, numerator of the fraction of the span
	typedef struct packed {
		logic       ladder_on;
		logic       pin_connect;
		logic       span_external;
		logic       low_range;
		logic [4:0] tap_numerator;
	} vrc_ladder_s;

endpackage

// ==== vrc_tap_decode.sv ====
`timescale 1ns/10ps
module vrc_tap_decode
	import vrc_pkg::*;
(
	input  wire vrc_ctrl_s   ctrl,
	output      vrc_ladder_s ladder
);

	always_comb begin
		ladder.ladder_on     = ctrl.ref_power_enable;
		ladder.pin_connect   = ctrl.ref_power_enable
			& ctrl.ref_pin_output_enable;
		ladder.span_external = ctrl.ref_source_select;
		ladder.low_range     = ctrl.ref_range_select;
		if (ctrl.ref_range_select) begin
			// Level = tap/24 of span
			ladder.tap_numerator = {1'b0, ctrl.ref_tap_value};
		end else begin
			// Level = 8/32 + tap/32 of span
			ladder.tap_numerator = VRC_HIGH_OFFSET
				+ {1'b0, ctrl.ref_tap_value};
		end
	end

endmodule

// ==== vrc_top_tb.sv ====
`timescale 1ns/10ps
module vrc_top_tb;
	import vrc_pkg::*;
	typedef struct packed {
		logic [7:0] data;
		logic       dir;
		logic [4:0] tap_num;
	} vrc_row_s;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        port_f_direction = 1'b1;
	logic        ladder_power_on;
	logic        ref_output_pin_connect;
	logic        span_external;
	logic        low_range;
	logic [4:0]  tap_numerator;
	logic [3:0]  ref_tap_value;
	logic [31:0] rd;
	logic        err;
	int          errors = 0;
	int          total_checks = 0;
	// Ends of both ranges, pin gating by power and direction
	vrc_row_s    rows [6] = '{{8'hFF, 1'b1, 5'h0F}, {8'hDF, 1'b1, 5'h17},
		{8'hC0, 1'b0, 5'h08}, {8'h30, 1'b1, 5'h00},
		{8'h5A, 1'b1, 5'h12}, {8'hC7, 1'b1, 5'h0F}};
	vrc_top u_dut (.*);
	always #12.5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h got %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1; pwrite <= w; paddr <= a;
		pwdata <= {24'h0, d}; pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		do begin @(posedge mclk); n++; end
		while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic outs(input logic [7:0] d, input logic dir,
		input logic [4:0] tn);
		chk("power", {31'h0, d[7]}, {31'h0, ladder_power_on});
		chk("pin", {31'h0, d[7] & d[6] & dir},
			{31'h0, ref_output_pin_connect});
		chk("range", {31'h0, d[5]}, {31'h0, low_range});
		chk("tap_num", {27'h0, tn}, {27'h0, tap_numerator});
		chk("span", {31'h0, d[4]}, {31'h0, span_external});
		chk("tap", {28'h0, d[3:0]}, {28'h0, ref_tap_value});
	endtask
	task print_verdict;
		$display("Checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 3000);
		errors++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		outs(8'h00, 1'b1, 5'h08);
		apb(1'b0, VRC_ADDR_CTRL, 8'h00, 4'hF);
		chk("reset read", 32'h0, rd);
		$display("Test reset done");
		foreach (rows[i]) begin
			@(posedge mclk);
			port_f_direction <= rows[i].dir;
			apb(1'b1, VRC_ADDR_CTRL, rows[i].data, 4'h1);
			repeat (2) @(posedge mclk);
			#1;
			outs(rows[i].data, rows[i].dir, rows[i].tap_num);
			apb(1'b0, VRC_ADDR_CTRL, 8'h00, 4'hF);
			chk("readback", {24'h0, rows[i].data}, rd);
		end
		$display("Test table done");
		apb(1'b1, 12'h004, 8'h00, 4'hF);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b0, 12'h004, 8'h00, 4'hF);
		chk("unmapped", 32'h0, rd);
		apb(1'b1, VRC_ADDR_CTRL, 8'h00, 4'h0);
		chk("no strobe err", 32'h0, {31'h0, err});
		apb(1'b0, VRC_ADDR_CTRL, 8'h00, 4'hF);
		chk("kept", 32'h0000_00C7, rd);
		$display("Test refusal done");
		apb(1'b1, VRC_ADDR_CTRL, 8'h00, 4'h1);
		repeat (2) @(posedge mclk);
		#1;
		outs(8'h00, 1'b1, 5'h08);
		$display("Test disable done");
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		outs(8'h00, 1'b1, 5'h08);
		$display("Test mid reset done");
		print_verdict;
	end
endmodule
